// ---- common/stc_pkg.sv ----
// constants, types and register map of the ten-bit comma-align serdes
package stc_pkg;
   // word and pattern layout
   localparam int         WORD_W      = 10;
   localparam logic [9:0] COMMA_WORD  = 10'h17c;  // alignment char, bit 0 first
   localparam logic [9:0] WORD_ZERO   = 10'h000;
   localparam logic [3:0] POS_LAST    = 4'h9;     // last bit of a word
   localparam logic [3:0] HALF_LAST   = 4'h9;     // last bit of a half clock
   localparam logic [3:0] HALF_RESTART = 4'h1;    // half count after realign
   localparam logic [3:0] CNT_ZERO    = 4'h0;
   localparam logic [3:0] CNT_ONE     = 4'h1;
   // clock-rate and lock timing
   localparam int CLK_MHZ       = 25;
   localparam int INIT_LOCK_US  = 500;
   localparam int RELOCK_NS     = 2400;
   localparam int INIT_LOCK_CYC = INIT_LOCK_US * CLK_MHZ;
   localparam int RELOCK_CYC    = (RELOCK_NS * CLK_MHZ) / 1000;
   // run lengths that flag a disturbed stream
   localparam logic [4:0] RUN_SLIP  = 5'h06;
   localparam logic [4:0] RUN_LOSS  = 5'h14;
   localparam logic [4:0] RUN_ZERO  = 5'h00;
   localparam logic [4:0] RUN_ONE   = 5'h01;
   // register map
   localparam int          ADDR_W          = 12;
   localparam logic [11:0] CTRL_OFFSET     = 12'h000;
   localparam logic [11:0] STATUS_OFFSET   = 12'h004;
   localparam logic [11:0] COMMA_OFFSET    = 12'h008;
   localparam logic [11:0] REALIGN_OFFSET  = 12'h00c;
   localparam int          CTRL_ALIGN_BIT  = 0;
   localparam int          CTRL_LOOP_BIT   = 1;
   localparam int          CTRL_REF_BIT    = 2;
   localparam logic [2:0]  CTRL_RESET      = 3'h0;
   localparam logic [15:0] COUNT_ZERO      = 16'h0000;
   localparam logic [15:0] COUNT_ONE       = 16'h0001;
   localparam logic [31:0] DATA_ZERO       = 32'h0000_0000;
   localparam logic [31:0] TIMER_ZERO      = 32'h0000_0000;
   localparam logic [31:0] TIMER_ONE       = 32'h0000_0001;
   // receive lock states
   typedef enum logic [1:0] {
      LK_ACQUIRE,
      LK_LOCKED,
      LK_TRACK,
      LK_REFERENCE
   } stc_lock_e;
endpackage

// ---- logic/stc_serdes.sv ----
// ten-bit serdes datapath with comma alignment, loopback and apb registers
`timescale 1ns/1ns
// What this block does
// - capture tx word on reference rising edge
// - bit clock is ten times reference
// - serialize bit 0 first up to 9
// - transmit latency about two bit clocks, 80 ns at 25 MHz
// - two antiphase byte clocks, divide by twenty
// - realigned alignment word valid at clock b rise
// - byte clocks only stretched, never shortened
// - byte clocks keep running on bad stream
// - auto lock, initial lock within 500 us
// - lock-to-reference presets the receiver
// - relock within 2.4 us after transient
// - compare serial window to alignment pattern
// - recognition uses full ten-bit character
// - on-boundary comma leaves boundary alone
// - straddling comma shifts boundary, next aligned
// - realign stretches at most ten bit times
// - comma detect high for one word
// - first received bit lands on bit 0
// - loopback routes tx internally, line static
// - comma detect only while align enabled
module stc_serdes
   import stc_pkg::*;
#(
   parameter int LOCK_INIT_CYC = stc_pkg::INIT_LOCK_CYC,
   parameter int LOCK_RELOCK_CYC = stc_pkg::RELOCK_CYC
) (
   input  wire logic                        clk,
   input  wire logic                        reset_n,
   input  wire logic                        clk_en,
   // parallel transmit side
   input  wire logic [stc_pkg::WORD_W-1:0]  tx_parallel_word,
   input  wire logic                        reference_clock_in,
   // serial line
   output logic                             tx_serial_p,
   output logic                             tx_serial_n,
   input  wire logic                        rx_serial_in,
   // parallel receive side
   output logic [stc_pkg::WORD_W-1:0]       rx_parallel_word,
   output logic                             rx_byte_clock_a,
   output logic                             rx_byte_clock_b,
   output logic                             comma_detect,
   output logic                             rx_locked,
   // mode pins
   input  wire logic                        comma_align_enable,
   input  wire logic                        lock_to_ref_select,
   input  wire logic                        internal_loopback_enable,
   // apb slave
   input  wire logic                        psel,
   input  wire logic                        penable,
   input  wire logic                        pwrite,
   input  wire logic [stc_pkg::ADDR_W-1:0]  paddr,
   input  wire logic [31:0]                 pwdata,
   input  wire logic [3:0]                  pstrb,
   output logic [31:0]                      prdata,
   output logic                             pready,
   output logic                             pslverr
);
   import stc_pkg::*;

   // software control bits, or-ed with the pins
   logic [2:0]         ctrl;          // soft enables
   logic [2:0]         next_ctrl;
   logic               align_on;      // alignment active
   logic               loop_on;       // internal loopback active
   logic               ref_on;        // lock to reference active
   // transmit path
   logic               ref_q;         // reference pin last sample
   logic               ref_rise;      // reference rising edge seen
   logic [WORD_W-1:0]  tx_shift;      // transmit shift register
   logic [WORD_W-1:0]  next_tx_shift;
   logic               next_tx_p;
   logic               next_tx_n;
   // receive lock
   logic               rx_bit;        // selected serial input
   logic               rx_last;       // previous serial bit
   logic [4:0]         run;           // identical-bit run length
   logic [4:0]         next_run;
   stc_lock_e          lock_st;       // receive lock state
   stc_lock_e          next_lock_st;
   logic [31:0]        tmr;           // lock timer
   logic [31:0]        next_tmr;
   // word alignment
   logic [WORD_W-1:0]  hist;          // last ten received bits
   logic [3:0]         pos;           // bit position in word
   logic [3:0]         next_pos;
   logic [3:0]         half;          // bit count in byte-clock half
   logic [3:0]         next_half;
   logic [WORD_W-1:0]  ready;         // word waiting for a clock edge
   logic [WORD_W-1:0]  next_ready;
   logic               ready_comma;   // waiting word is the comma
   logic               next_ready_comma;
   logic               pend;          // comma waits for clock b rise
   logic               next_pend;
   logic [WORD_W-1:0]  next_rx_word;
   logic               next_comma_det;
   logic               next_clk_b;
   logic               comma_seen;    // comma in the window now
   logic               on_bound;      // window is on word boundary
   logic               realign;       // comma straddles boundary
   logic               take;          // capture window this bit
   logic               toggle;        // byte clocks change this bit
   // statistics
   logic [15:0]        comma_cnt;     // commas presented
   logic [15:0]        next_comma_cnt;
   logic [15:0]        realign_cnt;   // boundary shifts
   logic [15:0]        next_realign_cnt;
   // bus
   logic               wr_en;         // write in access phase
   logic               mapped;        // address hits a register
   logic [31:0]        rd_mux;        // read data before the flop

   // effective modes
   assign align_on = comma_align_enable | ctrl[CTRL_ALIGN_BIT];
   assign loop_on  = internal_loopback_enable | ctrl[CTRL_LOOP_BIT];
   assign ref_on   = lock_to_ref_select | ctrl[CTRL_REF_BIT];

   // transmit: load on reference edge, shift out lsb first
   always_comb begin
      ref_rise = reference_clock_in & ~ref_q;
      if (ref_rise) begin
         next_tx_shift = tx_parallel_word;
      end else begin
         next_tx_shift = {1'b0, tx_shift[WORD_W-1:1]};
      end
      // line held static while looped back
      next_tx_p = loop_on ? 1'b0 : tx_shift[0];
      next_tx_n = loop_on ? 1'b1 : ~tx_shift[0];
   end

   // transmit registers; clk is the ten-times bit clock
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         ref_q       <= 1'b0;
         tx_shift    <= WORD_ZERO;
         tx_serial_p <= 1'b0;
         tx_serial_n <= 1'b1;
      end else if (clk_en) begin
         ref_q       <= reference_clock_in;
         tx_shift    <= next_tx_shift;
         tx_serial_p <= next_tx_p;
         tx_serial_n <= next_tx_n;
      end
   end

   // serial input select: looped stream replaces the pin
   assign rx_bit = loop_on ? tx_shift[0] : rx_serial_in;

   // lock tracking from run lengths and timers
   always_comb begin
      next_lock_st = lock_st;
      next_tmr     = tmr;
      // run of identical bits, saturating
      if (rx_bit != rx_last) begin
         next_run = RUN_ZERO;
      end else if (run != RUN_LOSS) begin
         next_run = run + RUN_ONE;
      end else begin
         next_run = run;
      end
      if (ref_on) begin
         // preset: sit on the reference
         next_lock_st = LK_REFERENCE;
         next_tmr     = TIMER_ZERO;
      end else begin
         unique case (lock_st)
            LK_ACQUIRE: begin
               // power-up style acquisition
               if (tmr == TIMER_ZERO) begin
                  next_lock_st = LK_LOCKED;
               end else begin
                  next_tmr = tmr - TIMER_ONE;
               end
            end
            LK_LOCKED: begin
               // code-illegal run means a transient
               if (run == RUN_SLIP) begin
                  next_lock_st = LK_TRACK;
                  next_tmr = 32'(LOCK_RELOCK_CYC - 1);
               end
            end
            LK_TRACK: begin
               if (run == RUN_LOSS) begin
                  // too large: full reacquisition
                  next_lock_st = LK_ACQUIRE;
                  next_tmr = 32'(LOCK_INIT_CYC - 1);
               end else if (tmr == TIMER_ZERO) begin
                  next_lock_st = LK_LOCKED;
               end else begin
                  next_tmr = tmr - TIMER_ONE;
               end
            end
            LK_REFERENCE: begin
               // released preset: near rate, short relock
               next_lock_st = LK_TRACK;
               next_tmr = 32'(LOCK_RELOCK_CYC - 1);
            end
         endcase
      end
   end

   // lock registers
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         rx_last   <= 1'b0;
         run       <= RUN_ZERO;
         lock_st   <= LK_ACQUIRE;
         tmr       <= 32'(LOCK_INIT_CYC - 1);
         rx_locked <= 1'b0;
      end else if (clk_en) begin
         rx_last   <= rx_bit;
         run       <= next_run;
         lock_st   <= next_lock_st;
         tmr       <= next_tmr;
         rx_locked <= (next_lock_st == LK_LOCKED) ||
                      (next_lock_st == LK_REFERENCE);
      end
   end

   // word framing and byte clocks
   always_comb begin
      // full ten-bit compare, only when framing is on
      comma_seen = align_on && (lock_st == LK_LOCKED) &&
                   (hist == COMMA_WORD);
      on_bound   = (pos == POS_LAST);
      realign    = comma_seen && !on_bound;
      take       = on_bound || realign;
      // realign restarts the half: lengthens it only
      toggle     = (half == HALF_LAST) && !realign;
      next_pos         = take ? CNT_ZERO : pos + CNT_ONE;
      next_half        = realign ? HALF_RESTART :
                         (toggle ? CNT_ZERO : half + CNT_ONE);
      next_ready       = ready;
      next_ready_comma = ready_comma;
      next_pend        = pend;
      next_rx_word     = rx_parallel_word;
      next_comma_det   = comma_detect;
      next_clk_b       = rx_byte_clock_b;
      // only a realigned comma waits for clock b; the word behind it
      // is dropped if it ends before clock b rises, on-boundary commas keep their own slot
      if (take && !pend) begin
         next_ready       = hist;
         next_ready_comma = comma_seen;
         next_pend        = realign;
      end
      if (toggle) begin
         next_clk_b = ~rx_byte_clock_b;
         if (!rx_byte_clock_b) begin
            // rising edge of clock b: comma goes out here
            next_rx_word   = ready;
            next_comma_det = ready_comma;
            next_pend      = 1'b0;
         end else if (!pend) begin
            next_rx_word   = ready;
            next_comma_det = 1'b0;
         end else begin
            // hold data until clock b rises again
            next_comma_det = 1'b0;
         end
      end
   end

   // framing registers; reference preset clears the framing
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         hist             <= WORD_ZERO;
         pos              <= CNT_ZERO;
         half             <= CNT_ZERO;
         ready            <= WORD_ZERO;
         ready_comma      <= 1'b0;
         pend             <= 1'b0;
         rx_parallel_word <= WORD_ZERO;
         comma_detect     <= 1'b0;
         rx_byte_clock_a  <= 1'b1;
         rx_byte_clock_b  <= 1'b0;
      end else if (clk_en) begin
         hist             <= {rx_bit, hist[WORD_W-1:1]};
         half             <= next_half;
         rx_parallel_word <= next_rx_word;
         comma_detect     <= next_comma_det;
         rx_byte_clock_a  <= ~next_clk_b;
         rx_byte_clock_b  <= next_clk_b;
         if (ref_on) begin
            pos         <= CNT_ZERO;
            ready_comma <= 1'b0;
            pend        <= 1'b0;
            ready       <= next_ready;
         end else begin
            pos         <= next_pos;
            ready       <= next_ready;
            ready_comma <= next_ready_comma;
            pend        <= next_pend;
         end
      end
   end

   // statistics counters, wrap around
   always_comb begin
      next_comma_cnt   = comma_cnt;
      next_realign_cnt = realign_cnt;
      if (toggle && !rx_byte_clock_b && ready_comma) begin
         next_comma_cnt = comma_cnt + COUNT_ONE;
      end
      if (realign) begin
         next_realign_cnt = realign_cnt + COUNT_ONE;
      end
   end

   // counter registers
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         comma_cnt   <= COUNT_ZERO;
         realign_cnt <= COUNT_ZERO;
      end else if (clk_en) begin
         comma_cnt   <= next_comma_cnt;
         realign_cnt <= next_realign_cnt;
      end
   end

   // apb decode: zero-wait answer while enabled
   always_comb begin
      pready  = clk_en;
      mapped  = (paddr == CTRL_OFFSET) || (paddr == STATUS_OFFSET) ||
                (paddr == COMMA_OFFSET) || (paddr == REALIGN_OFFSET);
      pslverr = psel && penable && !mapped;
      wr_en   = psel && penable && pwrite && clk_en;
      next_ctrl = ctrl;
      if (wr_en && (paddr == CTRL_OFFSET) && pstrb[0]) begin
         next_ctrl = pwdata[2:0];
      end
      unique case (paddr)
         CTRL_OFFSET:    rd_mux = {29'h0000_0000, ctrl};
         STATUS_OFFSET:  rd_mux = {25'h000_0000, pend, comma_detect,
                                   rx_byte_clock_b, lock_st, rx_locked,
                                   loop_on};
         COMMA_OFFSET:   rd_mux = {16'h0000, comma_cnt};
         REALIGN_OFFSET: rd_mux = {16'h0000, realign_cnt};
         default:        rd_mux = DATA_ZERO;
      endcase
   end

   // apb registers: read data caught in the setup cycle
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         ctrl   <= CTRL_RESET;
         prdata <= DATA_ZERO;
      end else if (clk_en) begin
         ctrl <= next_ctrl;
         if (psel && !penable) begin
            prdata <= rd_mux;
         end
      end
   end

endmodule // stc_serdes

// ---- test/stc_link_partner.sv ----
// serial link partner model: sends words bit 0 first or echoes the tx line
`timescale 1ns/1ns
module stc_link_partner
   import stc_pkg::*;
(
   input  wire logic clk,
   input  wire logic loop_mode,
   input  wire logic tx_serial_p,
   output logic      rx_serial_in
);
   logic [9:0] word_q[$];        // words waiting to go out
   logic [9:0] shift = 10'h155;  // word on the line now
   logic [3:0] pos   = 4'h0;     // bit being sent
   logic       line  = 1'h0;     // own line level
   logic       stuck = 1'h0;     // inserted bits held low
   int         extra = 0;        // inserted bits still to go
   // queue one word
   task automatic send(input logic [9:0] w);
      word_q.push_back(w);
   endtask
   // insert n toggling bits, or n low bits
   task automatic hold(input int n, input logic low);
      extra = n;
      stuck = low;
   endtask
   // one bit per clock; idle words toggle so the line never sits still
   always @(posedge clk) begin
      if (extra > 0) begin
         extra <= extra - 1;
         line  <= stuck ? 1'h0 : ~line;
      end else begin
         line <= shift[pos];
         pos  <= (pos == POS_LAST) ? CNT_ZERO : pos + CNT_ONE;
         if (pos == POS_LAST) begin
            shift <= (word_q.size() > 0) ? word_q.pop_front() : 10'h155;
         end
      end
   end
   // echo mode hands the transmitted line straight back
   assign rx_serial_in = loop_mode ? tx_serial_p : line;
endmodule // stc_link_partner

// ---- test/stc_serdes_monitor.sv ----
// assertion checker on the ten-bit serdes ports
`timescale 1ns/1ns
module stc_serdes_monitor
   import stc_pkg::*;
#(
   parameter int LOCK_INIT_CYC = 20
) (
   input wire logic                       clk,
   input wire logic                       reset_n,
   input wire logic                       reference_clock_in,
   input wire logic [stc_pkg::WORD_W-1:0] tx_parallel_word,
   input wire logic                       tx_serial_p,
   input wire logic                       tx_serial_n,
   input wire logic [stc_pkg::WORD_W-1:0] rx_parallel_word,
   input wire logic                       rx_byte_clock_a,
   input wire logic                       rx_byte_clock_b,
   input wire logic                       comma_detect,
   input wire logic                       rx_locked,
   input wire logic                       comma_align_enable,
   input wire logic                       lock_to_ref_select,
   input wire logic                       internal_loopback_enable
);
   localparam int LOCK_MAX = LOCK_INIT_CYC + 10;  // lock bound after reset
   logic [4:0] half_cnt;  // cycles since last byte clock toggle
   logic       prev_b;    // byte clock b one cycle back
   logic       seen;      // a toggle seen since reset
   logic       chg;       // byte clock b toggles now
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);
   assign chg = rx_byte_clock_b != prev_b;
   // measure each byte clock half
   always_ff @(posedge clk) begin
      prev_b <= rx_byte_clock_b;
      seen   <= reset_n && (seen || chg);
      if (!reset_n || chg) begin
         half_cnt <= 5'h00;
      end else if (half_cnt != 5'h1f) begin
         half_cnt <= half_cnt + 5'h01;
      end
   end
   a_clocks_antiphase: assert property (
      rx_byte_clock_a != rx_byte_clock_b)
      else $error("byte clocks not in antiphase");
   a_half_short: assert property (seen && chg |-> half_cnt >= 5'h09)
      else $error("byte clock half shortened");
   a_half_stretch: assert property (seen |-> half_cnt <= 5'h13)
      else $error("byte clock half stretched too far");
   a_comma_pulse: assert property ($rose(comma_detect) |->
      $rose(rx_byte_clock_b) && rx_parallel_word == COMMA_WORD
      ##1 comma_detect[*8] ##1 comma_detect ##1 !comma_detect)
      else $error("comma detect pulse wrong");
   a_comma_gated: assert property (
      $rose(comma_detect) |-> comma_align_enable)
      else $error("comma detect while alignment off");
   a_loop_static: assert property (internal_loopback_enable[*2] |->
      !tx_serial_p && tx_serial_n)
      else $error("serial line moves in loopback");
   a_tx_bit_order: assert property ($rose(reference_clock_in) &&
      tx_parallel_word == COMMA_WORD && !internal_loopback_enable |->
      ##[1:4] !tx_serial_p ##1 !tx_serial_p ##1 tx_serial_p[*5]
      ##1 !tx_serial_p ##1 tx_serial_p ##1 !tx_serial_p)
      else $error("serial bit order wrong");
   a_lock_initial: assert property (
      $rose(reset_n) |-> ##[1:LOCK_MAX] rx_locked)
      else $error("no lock after reset");
   a_lock_ref: assert property (lock_to_ref_select[*3] |-> rx_locked)
      else $error("no lock while tied to reference");
   c_comma: cover property ($rose(comma_detect));
   c_stretch: cover property (seen && chg && half_cnt > 5'h09);
   c_loop: cover property (internal_loopback_enable && rx_locked);
endmodule // stc_serdes_monitor

bind stc_serdes stc_serdes_monitor #(.LOCK_INIT_CYC(LOCK_INIT_CYC)) u_mon (
   .clk, .reset_n, .reference_clock_in, .tx_parallel_word, .tx_serial_p,
   .tx_serial_n, .rx_parallel_word, .rx_byte_clock_a, .rx_byte_clock_b,
   .comma_detect, .rx_locked, .comma_align_enable, .lock_to_ref_select,
   .internal_loopback_enable);

// ---- test/stc_serdes_tb_top.sv ----
// self-checking bench for the ten-bit comma-align serdes
`timescale 1ns/1ns
module stc_serdes_tb_top;
   import stc_pkg::*;
   localparam int         LK_INIT = 20;       // shortened initial lock
   localparam int         LK_RE   = 5;        // shortened relock
   localparam logic [9:0] FILL    = 10'h155;  // idle word, runs of one
   logic        clk = 1'h0, reset_n = 1'h0, reference_clock_in = 1'h0;
   logic [9:0]  tx_parallel_word = FILL, rx_parallel_word;
   logic        tx_serial_p, tx_serial_n, rx_serial_in, loop_mode = 1'h0;
   logic        rx_byte_clock_a, rx_byte_clock_b, comma_detect, rx_locked;
   logic        comma_align_enable = 1'h1, lock_to_ref_select = 1'h0;
   logic        internal_loopback_enable = 1'h0, psel = 1'h0;
   logic        penable = 1'h0, pwrite = 1'h0, pready, pslverr, er;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, r0;
   logic        prev_b = 1'h0, armed = 1'h0;  // watcher state
   logic [9:0]  exp_q[$], tx_q[$];            // expected rx, pending tx
   int          errors = 0, compares = 0, seed = 12658;
   int          ph = 0, cyc = 0, det_n = 0, d;
   stc_serdes #(.LOCK_INIT_CYC(LK_INIT), .LOCK_RELOCK_CYC(LK_RE)) dut (
      .clk(clk), .reset_n(reset_n), .clk_en(1'h1),
      .tx_parallel_word(tx_parallel_word),
      .reference_clock_in(reference_clock_in), .tx_serial_p(tx_serial_p),
      .tx_serial_n(tx_serial_n), .rx_serial_in(rx_serial_in),
      .rx_parallel_word(rx_parallel_word), .rx_byte_clock_a(rx_byte_clock_a),
      .rx_byte_clock_b(rx_byte_clock_b), .comma_detect(comma_detect),
      .rx_locked(rx_locked), .comma_align_enable(comma_align_enable),
      .lock_to_ref_select(lock_to_ref_select),
      .internal_loopback_enable(internal_loopback_enable), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pstrb(4'hf), .prdata(prdata), .pready(pready), .pslverr(pslverr));
   stc_link_partner lp (.clk(clk), .loop_mode(loop_mode),
      .tx_serial_p(tx_serial_p), .rx_serial_in(rx_serial_in));
   always #20 clk = ~clk;
   task automatic check(input bit ok, input string m);
      compares++;
      if (!ok) begin
         errors++;
         $display("ERROR %0t %s", $time, m);
      end
   endtask
   task automatic summarize();
      $display("errors %0d compares %0d", errors, compares);
      if (errors == 0 && compares > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   // one apb transfer, held until pready at a rising edge
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] wd, output logic [31:0] q,
                      output logic e);
      @(posedge clk);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'h1;
      @(posedge clk);
      while (pready !== 1'h1) begin
         @(posedge clk);
      end
      q = prdata;
      e = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask
   task automatic reg_chk(input logic [11:0] a, input logic [31:0] x,
                          input logic xe);
      logic [31:0] q;
      logic        e;
      apb(1'h0, a, DATA_ZERO, q, e);
      check(q === x && e === xe, "register read");
   endtask
   // random word with runs of at most two
   function automatic logic [9:0] manch(input logic [31:0] r);
      logic [9:0] w;
      for (int i = 0; i < 5; i++) begin
         w[2*i] = r[i];
         w[2*i+1] = ~r[i];
      end
      return w;
   endfunction
   task automatic wait_lock(input int lim);
      int n;
      n = 0;
      while (rx_locked !== 1'h1 && n < lim) begin
         @(posedge clk);
         n++;
      end
      check(rx_locked === 1'h1, "no lock in time");
   endtask
   // three commas then eight data words, by partner or by own tx
   task automatic frame(input logic on_tx);
      logic [9:0] w;
      int         n;
      for (n = 0; n < 11; n++) begin
         w = (n < 3) ? COMMA_WORD : manch($random(seed));
         if (n >= 3) exp_q.push_back(w);
         if (on_tx) tx_q.push_back(w);
         else lp.send(w);
      end
      n = 0;
      while (exp_q.size() > 0 && n < 400) begin
         @(posedge clk);
         n++;
      end
      check(exp_q.size() == 0, "frame words missing");
      exp_q.delete();
   endtask
   // reference clock and tx words, one word per ten bits
   always @(posedge clk) begin
      ph <= (ph == 9) ? 0 : ph + 1;
      cyc <= cyc + 1;
      if (ph == 0) reference_clock_in <= 1'h1;
      if (ph == 5) begin
         reference_clock_in <= 1'h0;
         tx_parallel_word <= (tx_q.size() > 0) ? tx_q.pop_front() : FILL;
      end
      if (cyc == 20000) begin
         errors++;
         $display("ERROR %0t run timed out", $time);
         summarize();
      end
   end
   // watcher: compares each new rx word after a comma with the oldest note
   always @(posedge clk) begin
      prev_b <= rx_byte_clock_b;
      if (comma_detect === 1'h1) det_n <= det_n + 1;
      if (exp_q.size() == 0) armed <= 1'h0;
      else if (comma_detect === 1'h1) armed <= 1'h1;
      if (armed && rx_byte_clock_b !== prev_b && exp_q.size() > 0 &&
          rx_parallel_word !== COMMA_WORD)
         check(rx_parallel_word === exp_q.pop_front(), "rx word");
   end
   initial begin
      repeat (12) @(posedge clk);
      reset_n <= 1'h1;
      reg_chk(CTRL_OFFSET, DATA_ZERO, 1'h0);
      reg_chk(COMMA_OFFSET, DATA_ZERO, 1'h0);
      apb(1'h1, COMMA_OFFSET, 32'h5, r0, er);
      reg_chk(COMMA_OFFSET, DATA_ZERO, 1'h0);
      reg_chk(REALIGN_OFFSET, DATA_ZERO, 1'h0);
      reg_chk(12'h010, DATA_ZERO, 1'h1);
      $display("test registers done");
      wait_lock(LK_INIT + 10);
      frame(1'h0);
      $display("test partner frame done");
      apb(1'h0, REALIGN_OFFSET, DATA_ZERO, r0, er);
      lp.hold(3, 1'h0);
      frame(1'h0);
      reg_chk(REALIGN_OFFSET, r0 + 32'h1, 1'h0);
      $display("test realign done");
      loop_mode <= 1'h1;
      frame(1'h1);
      loop_mode <= 1'h0;
      $display("test line echo done");
      comma_align_enable <= 1'h0;
      d = det_n;
      repeat (3) lp.send(COMMA_WORD);
      repeat (200) @(posedge clk);
      check(det_n == d, "comma detect while alignment off");
      comma_align_enable <= 1'h1;
      lock_to_ref_select <= 1'h1;
      repeat (4) @(posedge clk);
      check(rx_locked === 1'h1, "reference lock");
      lock_to_ref_select <= 1'h0;
      $display("test modes done");
      internal_loopback_enable <= 1'h1;
      lp.hold(300, 1'h1);
      frame(1'h1);
      internal_loopback_enable <= 1'h0;
      while (lp.extra > 0) @(posedge clk);
      wait_lock(LK_INIT + LK_RE + 500);
      frame(1'h0);
      $display("test loopback and relock done");
      summarize();
   end
endmodule // stc_serdes_tb_top
